// [logic/pmw_pkg.sv]
// Package of constants and types for the power-mode and wake-up controller.
package pmw_pkg;

  // ==========================================================================
  // Power modes.
  typedef enum logic [1:0] {
    PMW_NORMAL   = 2'b00,
    PMW_IDLE     = 2'b01,
    PMW_PWRDOWN  = 2'b10,
    PMW_WAKEWAIT = 2'b11
  } pmw_mode_t;

  // ==========================================================================
  // Wake source vector layout.
  localparam int WK_BROWNOUT  = 0;
  localparam int WK_VDETECT   = 1;
  localparam int WK_GPIO      = 2;
  localparam int WK_TIMER     = 3;
  localparam int WK_WATCHDOG  = 4;
  localparam int WK_RTC_ALARM = 5;
  localparam int WK_RTC_TICK  = 6;
  localparam int WK_SERIAL    = 7;
  localparam int WK_UNIVERSAL = 8;
  localparam int WK_TWOWIRE   = 9;
  localparam int WK_USB       = 10;
  localparam int WK_CMP0      = 11;
  localparam int WK_CMP1      = 12;
  localparam int WK_COUNT     = 13;

  // ==========================================================================
  // Flag bit positions inside the peripheral status words.
  localparam int BROWNOUT_FLAG_BIT = 4;
  localparam int VOLTDET_FLAG_BIT  = 19;
  localparam int TMR_IRQ_BIT     = 0;
  localparam int TMR_WAKE_BIT    = 1;
  localparam int WDOG_WAKE_BIT   = 5;
  localparam int RTC_ALARM_BIT   = 0;
  localparam int RTC_TICK_BIT    = 1;
  localparam int UART_WAKE_LO    = 0;
  localparam int UART_WAKE_HI    = 4;
  localparam int USU_WAKE_BIT    = 0;
  localparam int USU_ACK_BIT     = 16;
  localparam int TW_WAKE_BIT     = 0;
  localparam int TW_ACK_BIT      = 1;
  localparam int USB_BUS_BIT     = 0;
  localparam int CMP0_WAKE_BIT   = 8;
  localparam int CMP1_WAKE_BIT   = 9;

  // ==========================================================================
  // Peripheral clock source selection codes.
  localparam logic [1:0] SRC_FAST      = 2'h0;
  localparam logic [1:0] SRC_LOW_XTAL  = 2'h1;
  localparam logic [1:0] SRC_LOW_RC    = 2'h2;

  // ==========================================================================
  // Oscillator settle time after wake.
  localparam int SETTLE_NS     = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [logic/pmw_power_ctrl.sv]
// Power-mode sequencer with wake flags and peripheral clock gating.
`timescale 1ns/100ps
module pmw_power_ctrl #(
  parameter int GPIO_PINS = 16,
  parameter int SETTLE    = pmw_pkg::SETTLE_CYC
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire logic                 clkEn,
  input  wire logic                 waitForInterruptInstr,
  input  wire logic                 sleepEnable,
  input  wire logic                 powerdownEnable,
  input  wire logic                 irqPending,
  input  wire logic                 lowSpeedCrystalOn,
  input  wire logic                 lowSpeedRcOscOn,
  input  wire logic [1:0]           timerClkSrc,
  input  wire logic                 watchdogFromRc,
  input  wire logic                 rtcFromCrystal,
  input  wire logic [1:0]           serialClkSrc,
  input  wire logic                 regUnlocked,
  input  wire logic                 oscStable,
  input  wire logic [pmw_pkg::WK_COUNT-1:0]  wakeEvent,
  input  wire logic [GPIO_PINS-1:0] gpioWakeEvent,
  input  wire logic [4:0]           serialWakeEvent,
  input  wire logic                 universalAckEvent,
  input  wire logic                 twoWireAckEvent,
  input  wire logic [31:0]          brownoutCtlClr,
  input  wire logic [1:0]           timerStsClr,
  input  wire logic [31:0]          watchdogCtlClr,
  input  wire logic [1:0]           rtcStsClr,
  input  wire logic [4:0]           serialStsClr,
  input  wire logic [31:0]          universalStsClr,
  input  wire logic [1:0]           twoWireStsClr,
  input  wire logic                 usbStsClr,
  input  wire logic [9:0]           cmpStsClr,
  input  wire logic [GPIO_PINS-1:0] portIrqSourceClr,
  output logic [1:0]                powerMode,
  output logic                      cpuClkOn,
  output logic                      fastClksOn,
  output logic                      lowSpeedCrystalRun,
  output logic                      lowSpeedRcOscRun,
  output logic                      timerClkOn,
  output logic                      watchdogClkOn,
  output logic                      windowWatchdogClkOn,
  output logic                      rtcClkOn,
  output logic                      serialClkOn,
  output logic                      sramRetain,
  output logic [pmw_pkg::WK_COUNT-1:0] wakeFlags,
  output logic [GPIO_PINS-1:0]      portIrqSource,
  output logic [4:0]                serialWakeFlags,
  output logic                      timerIrqFlag,
  output logic                      universalAckDone,
  output logic                      twoWireAckDone
);

  // ==========================================================================
  // Wake flags: set wins over a write-one clear in the same cycle.
  logic [pmw_pkg::WK_COUNT-1:0] wakeFlags_q;
  logic [pmw_pkg::WK_COUNT-1:0] flagClr;
  logic [GPIO_PINS-1:0]         portSrc_q;
  logic [4:0]                   serialWk_q;
  logic                         timerIrq_q;
  logic                         uAck_q;
  logic                         twAck_q;
  logic                         anyFlag;

  always_comb begin
    flagClr = '0;
    flagClr[pmw_pkg::WK_BROWNOUT]  = brownoutCtlClr[pmw_pkg::BROWNOUT_FLAG_BIT];
    flagClr[pmw_pkg::WK_VDETECT]   = brownoutCtlClr[pmw_pkg::VOLTDET_FLAG_BIT];
    flagClr[pmw_pkg::WK_GPIO]      = 1'b0;
    flagClr[pmw_pkg::WK_TIMER]     = timerStsClr[pmw_pkg::TMR_WAKE_BIT];
    flagClr[pmw_pkg::WK_WATCHDOG]  = watchdogCtlClr[pmw_pkg::WDOG_WAKE_BIT] & regUnlocked;
    flagClr[pmw_pkg::WK_RTC_ALARM] = rtcStsClr[pmw_pkg::RTC_ALARM_BIT];
    flagClr[pmw_pkg::WK_RTC_TICK]  = rtcStsClr[pmw_pkg::RTC_TICK_BIT];
    flagClr[pmw_pkg::WK_SERIAL]    = 1'b0;
    flagClr[pmw_pkg::WK_UNIVERSAL] = universalStsClr[pmw_pkg::USU_WAKE_BIT] & ~uAck_q;
    flagClr[pmw_pkg::WK_TWOWIRE]   = twoWireStsClr[pmw_pkg::TW_WAKE_BIT] & ~twAck_q;
    flagClr[pmw_pkg::WK_USB]       = usbStsClr;
    flagClr[pmw_pkg::WK_CMP0]      = cmpStsClr[pmw_pkg::CMP0_WAKE_BIT];
    flagClr[pmw_pkg::WK_CMP1]      = cmpStsClr[pmw_pkg::CMP1_WAKE_BIT];
  end

  // The GPIO and serial summary bits follow their per-source flags.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wakeFlags_q <= '0;
    end else if (clkEn) begin
      wakeFlags_q <= (wakeFlags_q & ~flagClr) | wakeEvent;
      wakeFlags_q[pmw_pkg::WK_GPIO]   <= |((portSrc_q & ~portIrqSourceClr) | gpioWakeEvent);
      wakeFlags_q[pmw_pkg::WK_SERIAL] <= |((serialWk_q & ~serialStsClr) | serialWakeEvent);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      portSrc_q  <= '0;
      serialWk_q <= '0;
      timerIrq_q <= 1'b0;
    end else if (clkEn) begin
      portSrc_q  <= (portSrc_q & ~portIrqSourceClr) | gpioWakeEvent;
      serialWk_q <= (serialWk_q & ~serialStsClr) | serialWakeEvent;
      timerIrq_q <= (timerIrq_q & ~timerStsClr[pmw_pkg::TMR_IRQ_BIT]) | wakeEvent[pmw_pkg::WK_TIMER];
    end
  end

  // The acknowledge-done flag must be cleared before its wake flag will clear.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      uAck_q  <= 1'b0;
      twAck_q <= 1'b0;
    end else if (clkEn) begin
      uAck_q  <= (uAck_q & ~universalStsClr[pmw_pkg::USU_ACK_BIT]) | universalAckEvent;
      twAck_q <= (twAck_q & ~twoWireStsClr[pmw_pkg::TW_ACK_BIT]) | twoWireAckEvent;
    end
  end

  assign anyFlag = (|wakeFlags_q) | timerIrq_q;

  // ==========================================================================
  // Mode sequencer.
  pmw_pkg::pmw_mode_t mode_q;
  logic [$clog2(SETTLE+1)-1:0] settle_q;
  logic                        pdReq;

  assign pdReq = waitForInterruptInstr & sleepEnable & powerdownEnable;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_q <= pmw_pkg::PMW_NORMAL;
    end else if (clkEn) begin
      case (mode_q)
        pmw_pkg::PMW_NORMAL: begin
          // A stale flag would wake at once, so power-down is skipped entirely.
          if (pdReq && !anyFlag) begin
            mode_q <= pmw_pkg::PMW_PWRDOWN;
          end else if (waitForInterruptInstr && !pdReq) begin
            mode_q <= pmw_pkg::PMW_IDLE;
          end
        end
        pmw_pkg::PMW_IDLE: begin
          if (irqPending) begin
            mode_q <= pmw_pkg::PMW_NORMAL;
          end
        end
        pmw_pkg::PMW_PWRDOWN: begin
          if (anyFlag) begin
            mode_q <= pmw_pkg::PMW_WAKEWAIT;
          end
        end
        pmw_pkg::PMW_WAKEWAIT: begin
          if (oscStable && settle_q == '0) begin
            mode_q <= pmw_pkg::PMW_NORMAL;
          end
        end
        default: mode_q <= pmw_pkg::PMW_NORMAL;
      endcase
    end
  end

  // Settle counter guards against an oscillator that reports stable too early.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      settle_q <= '0;
    end else if (clkEn) begin
      if (mode_q == pmw_pkg::PMW_PWRDOWN) begin
        settle_q <= ($clog2(SETTLE+1))'(SETTLE);
      end else if (settle_q != '0) begin
        settle_q <= settle_q - 1'b1;
      end
    end
  end

  // ==========================================================================
  // Clock gating per mode.
  logic inPd;
  logic lowXtalRun;
  logic lowRcRun;
  assign inPd       = (mode_q == pmw_pkg::PMW_PWRDOWN);
  assign lowXtalRun = lowSpeedCrystalOn;
  assign lowRcRun   = lowSpeedRcOscOn;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cpuClkOn            <= 1'b1;
      fastClksOn          <= 1'b1;
      lowSpeedCrystalRun  <= 1'b0;
      lowSpeedRcOscRun    <= 1'b0;
      timerClkOn          <= 1'b1;
      watchdogClkOn       <= 1'b1;
      windowWatchdogClkOn <= 1'b1;
      rtcClkOn            <= 1'b1;
      serialClkOn         <= 1'b1;
    end else if (clkEn) begin
      cpuClkOn            <= (mode_q == pmw_pkg::PMW_NORMAL);
      fastClksOn          <= !inPd;
      lowSpeedCrystalRun  <= lowXtalRun;
      lowSpeedRcOscRun    <= lowRcRun;
      timerClkOn          <= !inPd || (timerClkSrc == pmw_pkg::SRC_LOW_XTAL && lowXtalRun)
                                   || (timerClkSrc == pmw_pkg::SRC_LOW_RC && lowRcRun);
      watchdogClkOn       <= !inPd || (watchdogFromRc && lowRcRun);
      windowWatchdogClkOn <= !inPd;
      rtcClkOn            <= !inPd || (rtcFromCrystal && lowXtalRun);
      serialClkOn         <= !inPd || (serialClkSrc == pmw_pkg::SRC_LOW_XTAL && lowXtalRun);
    end
  end

  assign powerMode        = mode_q;
  assign sramRetain       = 1'b1;
  assign wakeFlags        = wakeFlags_q;
  assign portIrqSource    = portSrc_q;
  assign serialWakeFlags  = serialWk_q;
  assign timerIrqFlag     = timerIrq_q;
  assign universalAckDone = uAck_q;
  assign twoWireAckDone   = twAck_q;

  // ==========================================================================
  // Checks.
  a_pd_entry_cond: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && $changed(mode_q) && mode_q == pmw_pkg::PMW_PWRDOWN |-> $past(pdReq) && !$past(anyFlag))
    else $error("Power-down entered without enables");
  a_idle_cpu_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && mode_q == pmw_pkg::PMW_IDLE ##1 clkEn |-> !cpuClkOn && fastClksOn)
    else $error("Idle clocks wrong");
  a_idle_wake: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && mode_q == pmw_pkg::PMW_IDLE && irqPending |=> mode_q == pmw_pkg::PMW_NORMAL)
    else $error("Idle did not wake");
  a_pd_fast_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && inPd ##1 clkEn |-> !fastClksOn && !windowWatchdogClkOn)
    else $error("Fast clocks running in power-down");
  a_pd_wake: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && inPd && anyFlag |=> mode_q == pmw_pkg::PMW_WAKEWAIT)
    else $error("Power-down did not wake");
  a_stale_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && mode_q == pmw_pkg::PMW_NORMAL && pdReq && anyFlag |=> mode_q != pmw_pkg::PMW_PWRDOWN)
    else $error("Stale flag allowed power-down");
  a_wdt_protect: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && wakeFlags_q[pmw_pkg::WK_WATCHDOG] && !regUnlocked |=> wakeFlags_q[pmw_pkg::WK_WATCHDOG])
    else $error("Protected watchdog flag cleared");
  a_tw_order: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && twAck_q && wakeFlags_q[pmw_pkg::WK_TWOWIRE] |=> wakeFlags_q[pmw_pkg::WK_TWOWIRE])
    else $error("Two-wire wake cleared before ack");
  a_cpu_stable: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && mode_q == pmw_pkg::PMW_WAKEWAIT && !oscStable |=> mode_q == pmw_pkg::PMW_WAKEWAIT)
    else $error("Processor released before stable");
  a_rtc_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && inPd && !lowSpeedCrystalOn ##1 clkEn |-> !rtcClkOn)
    else $error("Real-time clock ran without crystal");

  c_idle_trip:   cover property (@(posedge core_clk) mode_q == pmw_pkg::PMW_IDLE ##[1:20] mode_q == pmw_pkg::PMW_NORMAL);
  c_pd_trip:     cover property (@(posedge core_clk) inPd ##[1:300] mode_q == pmw_pkg::PMW_NORMAL);
  c_stale_block: cover property (@(posedge core_clk) pdReq && anyFlag && mode_q == pmw_pkg::PMW_NORMAL);

endmodule

// [verif/pmw_periph_model.sv]
// Behavioural wake-capable peripherals that raise wake and acknowledge events.
`timescale 1ns/100ps
module pmw_periph_model #(
  parameter int GPIO_PINS = 4
) (
  input  wire logic                         core_clk,
  output logic [pmw_pkg::WK_COUNT-1:0]      wakeEvent,
  output logic [GPIO_PINS-1:0]              gpioWakeEvent,
  output logic [4:0]                        serialWakeEvent,
  output logic                              universalAckEvent,
  output logic                              twoWireAckEvent
);
  // ==========================================================================
  // Idle state.
  initial begin
    {wakeEvent, gpioWakeEvent, serialWakeEvent, universalAckEvent, twoWireAckEvent} = '0;
  end

  // ==========================================================================
  // Event pulse.
  // Each event lasts exactly one cycle; a longer pulse would hide a missed edge.
  task automatic fire(input int src, input int sub, input bit ack);
    @(negedge core_clk);
    if (src == pmw_pkg::WK_GPIO) gpioWakeEvent[sub] = 1'b1;
    else if (src == pmw_pkg::WK_SERIAL) serialWakeEvent[sub] = 1'b1;
    else wakeEvent[src] = 1'b1;
    universalAckEvent = ack && src == pmw_pkg::WK_UNIVERSAL;
    twoWireAckEvent = ack && src == pmw_pkg::WK_TWOWIRE;
    @(negedge core_clk);
    {wakeEvent, gpioWakeEvent, serialWakeEvent, universalAckEvent, twoWireAckEvent} = '0;
  endtask
endmodule

// [verif/pmw_power_ctrl_tb_top.sv]
// Self-checking bench for the power-mode and wake-up controller.
`timescale 1ns/100ps
module pmw_power_ctrl_tb_top;
  localparam int PINS = 4;
  localparam int SET  = 2;
  logic            core_clk, rst_b, clkEn, waitInstr, sleepEn, powerdown_enable, irqPending, lxOn, lrcOn, wdRc, rtcXt, unlocked;
  logic            oscStable, usbClr, cpuClkOn, fastClksOn, lxRun, lrcRun, tmrOn, wdOn, wwdOn, rtcOn, serOn;
  logic            sramRetain, timerIrqFlag, usuAck, twAck, usuAckEv, twAckEv;
  logic [31:0]     brownClr, wdClr, usuClr;
  logic [1:0]      tmrClr, rtcClr, twClr, tmrSrc, serSrc, powerMode;
  logic [4:0]      serClr, serFlags, serEv;
  logic [9:0]      cmpClr;
  logic [12:0]     wakeFlags, wkEv;
  logic [PINS-1:0] gpioClr, portIrq, gpioEv;
  int              expFlags[13];
  int              num_errors;
  int              n_checks;

  pmw_periph_model #(.GPIO_PINS(PINS)) u_pmw_periph_model (.core_clk(core_clk), .wakeEvent(wkEv),
    .gpioWakeEvent(gpioEv), .serialWakeEvent(serEv), .universalAckEvent(usuAckEv), .twoWireAckEvent(twAckEv));

  pmw_power_ctrl #(.GPIO_PINS(PINS), .SETTLE(SET)) u_pmw_power_ctrl (.core_clk(core_clk), .rst_b(rst_b),
    .clkEn(clkEn), .waitForInterruptInstr(waitInstr), .sleepEnable(sleepEn), .powerdownEnable(powerdown_enable),
    .irqPending(irqPending), .lowSpeedCrystalOn(lxOn), .lowSpeedRcOscOn(lrcOn), .timerClkSrc(tmrSrc),
    .watchdogFromRc(wdRc), .rtcFromCrystal(rtcXt), .serialClkSrc(serSrc), .regUnlocked(unlocked),
    .oscStable(oscStable), .wakeEvent(wkEv), .gpioWakeEvent(gpioEv), .serialWakeEvent(serEv),
    .universalAckEvent(usuAckEv), .twoWireAckEvent(twAckEv), .brownoutCtlClr(brownClr), .timerStsClr(tmrClr),
    .watchdogCtlClr(wdClr), .rtcStsClr(rtcClr), .serialStsClr(serClr), .universalStsClr(usuClr),
    .twoWireStsClr(twClr), .usbStsClr(usbClr), .cmpStsClr(cmpClr), .portIrqSourceClr(gpioClr),
    .powerMode(powerMode), .cpuClkOn(cpuClkOn), .fastClksOn(fastClksOn), .lowSpeedCrystalRun(lxRun),
    .lowSpeedRcOscRun(lrcRun), .timerClkOn(tmrOn), .watchdogClkOn(wdOn), .windowWatchdogClkOn(wwdOn),
    .rtcClkOn(rtcOn), .serialClkOn(serOn), .sramRetain(sramRetain), .wakeFlags(wakeFlags),
    .portIrqSource(portIrq), .serialWakeFlags(serFlags), .timerIrqFlag(timerIrqFlag),
    .universalAckDone(usuAck), .twoWireAckDone(twAck));

  // ==========================================================================
  // Helpers.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [12:0] packFlags();
    logic [12:0] v;
    for (int i = 0; i < 13; i++) v[i] = expFlags[i][0];
    return v;
  endfunction

  task automatic waitMode(input logic [1:0] m);
    for (int i = 0; i < 40 && powerMode !== m; i++) @(negedge core_clk);
    check(powerMode, m);
  endtask

  // Enables settle one cycle before the instruction so the order is unambiguous.
  task automatic pulseWait(input logic [1:0] en);
    @(negedge core_clk);
    {sleepEn, powerdown_enable} = en;
    @(negedge core_clk);
    waitInstr = 1'b1;
    @(negedge core_clk);
    waitInstr = 1'b0;
  endtask

  task automatic clr(input int s, input int sub, input bit ack);
    @(negedge core_clk);
    case (s)
      0: brownClr[4] = 1'b1;
      1: brownClr[19] = 1'b1;
      2: gpioClr[sub] = 1'b1;
      3: tmrClr = 2'h3;
      4: wdClr[5] = 1'b1;
      5: rtcClr[0] = 1'b1;
      6: rtcClr[1] = 1'b1;
      7: serClr[sub] = 1'b1;
      8: usuClr[ack ? 16 : 0] = 1'b1;
      9: twClr[ack ? 1 : 0] = 1'b1;
      10: usbClr = 1'b1;
      default: cmpClr[s - 3] = 1'b1;
    endcase
    @(negedge core_clk);
    {brownClr, wdClr, usuClr, tmrClr, rtcClr, twClr, serClr, usbClr, cmpClr, gpioClr} = '0;
    @(negedge core_clk);
  endtask

  // ==========================================================================
  // One power-down round trip through a single wake source.
  task automatic pdCycle(input int s, input bit ack);
    int sub;
    sub = $urandom_range(s == 2 ? PINS - 1 : 4);
    @(negedge core_clk);
    {lxOn, lrcOn, wdRc, rtcXt} = 4'($urandom);
    tmrSrc = 2'($urandom_range(2));
    serSrc = 2'($urandom_range(2));
    oscStable = 1'b0;
    pulseWait(2'h3);
    waitMode(2);
    repeat (2) @(negedge core_clk);
    check({cpuClkOn, fastClksOn, wwdOn, sramRetain}, 4'b0001);
    check({lxRun, lrcRun}, {lxOn, lrcOn});
    check(tmrOn, (tmrSrc == 2'h1 && lxOn) || (tmrSrc == 2'h2 && lrcOn));
    check(wdOn, wdRc && lrcOn);
    check(rtcOn, rtcXt && lxOn);
    check(serOn, serSrc == 2'h1 && lxOn);
    u_pmw_periph_model.fire(s, sub, ack);
    expFlags[s] = 1;
    @(negedge core_clk);
    check(wakeFlags, packFlags());
    check(usuAck || twAck, ack);
    waitMode(3);
    repeat (SET + 4) @(negedge core_clk);
    check({powerMode, cpuClkOn}, 3'b110);
    oscStable = 1'b1;
    waitMode(0);
    @(negedge core_clk);
    check({cpuClkOn, fastClksOn}, 2'b11);
    pulseWait(2'h3);
    repeat (2) @(negedge core_clk);
    check(powerMode, 2'h0);
    unlocked = 1'b0;
    if (s == 4 || ack) begin
      clr(s, sub, 1'b0);
      check(wakeFlags[s], 1'b1);
    end
    unlocked = 1'b1;
    if (ack) clr(s, sub, 1'b1);
    clr(s, sub, 1'b0);
    expFlags[s] = 0;
    check({wakeFlags, portIrq, serFlags, timerIrqFlag, usuAck, twAck}, {packFlags(), 12'h0});
    // Without the enables the instruction only idles, so an interrupt must bring it back.
    pulseWait(2'h0);
    waitMode(1);
    irqPending = 1'b1;
    waitMode(0);
    irqPending = 1'b0;
  endtask

  // ==========================================================================
  // Verdict, clock, watchdog and main sequence.
  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #300000;
    num_errors++;
    test_done();
  end

  initial begin
    {rst_b, waitInstr, sleepEn, powerdown_enable, irqPending, lxOn, lrcOn, wdRc, rtcXt, tmrSrc, serSrc} = '0;
    {brownClr, wdClr, usuClr, tmrClr, rtcClr, twClr, serClr, usbClr, cmpClr, gpioClr} = '0;
    {clkEn, unlocked, oscStable} = 3'b111;
    void'($urandom(70602));
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    check({powerMode, cpuClkOn, fastClksOn, lxRun, lrcRun, wakeFlags}, 19'h18000);
    // A frozen clock enable must swallow a full power-down request.
    clkEn = 1'b0;
    pulseWait(2'h3);
    check(powerMode, 2'h0);
    clkEn = 1'b1;
    // Idle is reached with neither enable and with only one of the two.
    for (int e = 0; e < 3; e++) begin
      pulseWait(2'(e));
      waitMode(1);
      @(negedge core_clk);
      check({cpuClkOn, fastClksOn, wwdOn, tmrOn}, 4'b0111);
      irqPending = 1'b1;
      waitMode(0);
      irqPending = 1'b0;
    end
    for (int s = 0; s < 13; s++) pdCycle(s, 1'b0);
    pdCycle(8, 1'b1);
    pdCycle(9, 1'b1);
    test_done();
  end
endmodule
